/* File: hw/scil_top.sv */
`timescale 1ns/100ps
`include "scil_map.svh"
//
// Contract
// RQ1: terminal one run senses edge when sense switch on, level when off
// RQ2: protocol switch sampled after power-up; on gives Modbus, off alternate
// RQ3: node address from six switches; valid range one to sixty-three
// RQ4: four input selectors; terminals 1-3 take 0-10, terminal 4 0-11
// RQ5: two relay selectors taking 0-10, defaults two and one
// RQ6: input codes decode to none, run, alternate_ramp_select, jog, local and the rest
// RQ7: start or run only with permissive; its loss begins a stop
// RQ8: any run-assigned input with permissive starts; network needs none
// RQ9: power-on delay blocks run and jog until it expires
// RQ10: valid run starts start delay; ramp begins at its expiry
// RQ11: with alternate_ramp_select enabled, run change delay starts on run-to-stop
// RQ12: run active before enabled delay expires raises a warning
// RQ13: alternate_ramp_select select taken before run picks the alternate profile
// RQ14: jog follows ramp while held with permissive; never bypasses
// RQ15: local input selects terminal control; needed for terminal start
// RQ16: reset pulse clears latched fault only if no fault remains
// RQ17: loss of emergency input trips, removing power with no soft stop
// RQ18: loss of alarm-no-trip input enables reduced protection mode
// RQ19: loss of external trip input trips with no stop ramp
// RQ20: loss of external warning input reports warning, control continues
// RQ21: overload inhibit before start suppresses overload during ramp only
// RQ22: terminal four analog scales to percent against high, low thresholds
// RQ23: relay codes: none, fault, bypass, energized, warning, custom; even inverts
// RQ24: inputs synchronised; edge mode makes a one-cycle start request
//
module scil_top #(
   parameter int ADC_W = 12
) (
   // clock and reset
   input  wire logic                   I_SYS_CLK,
   input  wire logic                   I_RST,
   // terminals and switches
   input  wire logic                   i_permissive,
   input  wire logic [3:0]             i_terminal,
   input  wire logic                   i_sense_mode_switch,
   input  wire logic                   i_port_protocol_switch,
   input  wire logic [5:0]             i_addr_switch,
   // configuration
   input  wire scil_pkg::scil_code_t   i_in_fn_0,
   input  wire scil_pkg::scil_code_t   i_in_fn_1,
   input  wire scil_pkg::scil_code_t   i_in_fn_2,
   input  wire scil_pkg::scil_code_t   i_in_fn_3,
   input  wire scil_pkg::scil_code_t   i_relay_fn_0,
   input  wire scil_pkg::scil_code_t   i_relay_fn_1,
   input  wire logic                   i_cfg_wr,
   input  wire scil_pkg::scil_delays_s i_delays,
   input  wire logic                   i_alternate_ramp_select_enable,
   input  wire logic [6:0]             i_an_high,
   input  wire logic [6:0]             i_an_low,
   input  wire logic [1:0]             i_an_high_act,
   input  wire logic [1:0]             i_an_low_act,
   input  wire logic [ADC_W-1:0]       i_analog,
   // device status
   input  wire logic                   i_net_run,
   input  wire logic                   i_ramp_done,
   input  wire logic                   i_fault_cond,
   input  wire scil_pkg::scil_status_s i_status,
   // outputs
   output logic                        o_modbus_sel,
   output logic [5:0]                  o_node_addr,
   output logic                        o_addr_valid,
   output logic                        o_start_req,
   output logic                        o_ramp,
   output logic                        o_run,
   output logic                        o_stop,
   output logic                        o_hard_stop,
   output logic                        o_bypass_close,
   output logic                        o_alt_profile,
   output logic                        o_jog,
   output logic                        o_local,
   output logic                        o_fault,
   output logic                        o_warning,
   output logic                        o_alarm_no_trip,
   output logic                        o_ol_inhibit,
   output logic [6:0]                  o_analog_pct,
   output logic [1:0]                  o_relay
);
   import scil_pkg::*;

   // ----------------------------------------------------------------
   // configuration store
   // ----------------------------------------------------------------
   scil_code_t  in_fn_r [4];
   scil_code_t  rl_fn_r [2];
   // out-of-range codes are refused so a selector never holds junk
   // RQ4: input selector ranges
   wire ok0 = i_in_fn_0 <= `SCIL_FN_MAX_T13;
   wire ok1 = i_in_fn_1 <= `SCIL_FN_MAX_T13;
   wire ok2 = i_in_fn_2 <= `SCIL_FN_MAX_T13;
   wire ok3 = i_in_fn_3 <= `SCIL_FN_MAX_T4;
   // RQ5: relay selector ranges
   wire okr0 = i_relay_fn_0 <= `SCIL_RL_MAX;
   wire okr1 = i_relay_fn_1 <= `SCIL_RL_MAX;

   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         in_fn_r[0] <= `SCIL_IN1_DEF;
         in_fn_r[1] <= `SCIL_IN2_DEF;
         in_fn_r[2] <= `SCIL_IN3_DEF;
         in_fn_r[3] <= `SCIL_IN4_DEF;
         rl_fn_r[0] <= `SCIL_RL1_DEF;
         rl_fn_r[1] <= `SCIL_RL2_DEF;
      end else if (i_cfg_wr) begin
         if (ok0) in_fn_r[0] <= i_in_fn_0;
         if (ok1) in_fn_r[1] <= i_in_fn_1;
         if (ok2) in_fn_r[2] <= i_in_fn_2;
         if (ok3) in_fn_r[3] <= i_in_fn_3;
         if (okr0) rl_fn_r[0] <= i_relay_fn_0;
         if (okr1) rl_fn_r[1] <= i_relay_fn_1;
      end
   end

   // ----------------------------------------------------------------
   // input synchroniser
   // ----------------------------------------------------------------
   logic [4:0] s1_r, s2_r, s3_r;
   // RQ24: two-stage synchroniser
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         s1_r <= 5'h00;
         s2_r <= 5'h00;
         s3_r <= 5'h00;
      end else begin
         s1_r <= {i_permissive, i_terminal};
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   wire [3:0] term  = s2_r[3:0];
   wire [3:0] term_rise = s2_r[3:0] & ~s3_r[3:0];
   wire       perm  = s2_r[4];

   // ----------------------------------------------------------------
   // function decode
   // ----------------------------------------------------------------
   // RQ6: any terminal carrying a code; code none never matches
   function automatic logic any_fn(input scil_code_t c, input logic [3:0] v);
      logic r;
      r = 1'b0;
      for (int k = 0; k < 4; k++)
         if (in_fn_r[k] == c && c != `SCIL_FN_NONE) r |= v[k];
      return r;
   endfunction
   function automatic logic has_fn(input scil_code_t c);
      logic r;
      r = 1'b0;
      for (int k = 0; k < 4; k++)
         if (in_fn_r[k] == c) r = 1'b1;
      return r;
   endfunction
   // maintained inputs act on removal: the missing-signal state
   function automatic logic lost_fn(input scil_code_t c);
      logic r;
      r = 1'b0;
      for (int k = 0; k < 4; k++)
         if (in_fn_r[k] == c && !term[k]) r = 1'b1;
      return r;
   endfunction

   // RQ1: edge sensing applies to terminal one only
   wire run_command_input_edge = i_sense_mode_switch && in_fn_r[0] == `SCIL_FN_RUN;
   wire [3:0] run_view = run_command_input_edge ? {term[3:1], term_rise[0]} : term;
   // RQ8: several inputs may carry run
   wire run_term  = any_fn(`SCIL_FN_RUN, run_view);
   wire alternate_ramp_select_in  = any_fn(`SCIL_FN_ALTERNATE_RAMP_SELECT, term);
   wire jog_in    = any_fn(`SCIL_FN_JOG, term);
   // RQ15: local input gives terminal-block control
   wire local_in  = any_fn(`SCIL_FN_LOCAL, term);
   wire reset_p   = any_fn(`SCIL_FN_RESET, term_rise);
   wire oldis_in  = any_fn(`SCIL_FN_OLDIS, term);
   // RQ17: emergency trip on loss
   wire estop_t   = lost_fn(`SCIL_FN_ESTOP);
   // RQ19: external trip on loss
   wire xtrip_t   = lost_fn(`SCIL_FN_XTRIP);
   // RQ20: external warning on loss
   wire xwarn_t   = lost_fn(`SCIL_FN_XWARN);
   // RQ18: alarm-no-trip on loss
   wire ant_on    = lost_fn(`SCIL_FN_ANT);
   wire term_cmd  = local_in && has_fn(`SCIL_FN_RUN) && run_term;
   wire net_cmd   = !local_in && i_net_run;
   wire jog_cmd   = local_in && jog_in;

   // ----------------------------------------------------------------
   // analog input
   // ----------------------------------------------------------------
   // RQ22: scale to 0-99 and compare
   wire [ADC_W+6:0] an_prod = i_analog * `SCIL_PCT_FULL;
   wire [6:0] pct_nxt = 7'(an_prod >> ADC_W);
   wire an_on  = in_fn_r[3] == `SCIL_FN_ANALOG;
   wire an_hi  = an_on && o_analog_pct > i_an_high;
   wire an_lo  = an_on && o_analog_pct < i_an_low;
   wire an_trip = (an_hi && i_an_high_act == `SCIL_TH_TRIP) ||
                  (an_lo && i_an_low_act == `SCIL_TH_TRIP);
   wire an_warn = (an_hi && i_an_high_act == `SCIL_TH_WARN) ||
                  (an_lo && i_an_low_act == `SCIL_TH_WARN);

   // ----------------------------------------------------------------
   // start sequencer
   // ----------------------------------------------------------------
   scil_state_e st_r, st_nxt;
   logic [15:0] pon_r, dly_r, rchg_r;
   logic        was_run_r, cmd_r;
   wire  trip     = estop_t || xtrip_t || an_trip;
   // RQ9: power-on delay gate
   wire  pon_done = pon_r == 16'h0000;
   // RQ7: permissive gates all starts
   wire  cmd      = perm && pon_done && (term_cmd || net_cmd) && !o_fault;
   wire  jog_ok   = perm && pon_done && jog_cmd && !o_fault;
   wire  rchg_ok  = rchg_r == 16'h0000;
   wire  cmd_rise = cmd && (run_command_input_edge ? 1'b1 : !cmd_r);

   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         SCIL_ST_IDLE:  if (cmd_rise && rchg_ok) st_nxt = SCIL_ST_DELAY;
         // RQ10: ramp begins at delay expiry
         SCIL_ST_DELAY: if (dly_r == 16'h0000) st_nxt = SCIL_ST_RAMP;
         SCIL_ST_RAMP:  if (i_ramp_done) st_nxt = SCIL_ST_RUN;
         SCIL_ST_RUN:   st_nxt = SCIL_ST_RUN;
      endcase
      // edge mode latches; level mode drops on command removal
      if (!perm || trip || o_fault || (!run_command_input_edge && !cmd && !jog_ok))
         st_nxt = SCIL_ST_IDLE;
   end

   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         st_r <= SCIL_ST_IDLE;
         pon_r <= 16'hFFFF;
         dly_r <= 16'h0000;
         rchg_r <= 16'h0000;
         was_run_r <= 1'b0;
         cmd_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cmd_r <= cmd;
         was_run_r <= st_r != SCIL_ST_IDLE;
         // power-on count loads once its value is known after release
         if (pon_r == 16'hFFFF) pon_r <= i_delays.power_on;
         else if (!pon_done) pon_r <= pon_r - 16'h0001;
         if (st_r == SCIL_ST_IDLE) dly_r <= i_delays.start;
         else if (dly_r != 16'h0000) dly_r <= dly_r - 16'h0001;
         // RQ11: run change timer on run-to-stop
         if (i_alternate_ramp_select_enable && was_run_r && st_r == SCIL_ST_IDLE)
            rchg_r <= i_delays.run_change;
         else if (!rchg_ok) rchg_r <= rchg_r - 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // latched state and outputs
   // ----------------------------------------------------------------
   logic proto_done_r, alt_r, oli_r;
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         proto_done_r <= 1'b0;
         o_modbus_sel <= 1'b0;
         o_node_addr <= 6'h00;
         o_addr_valid <= 1'b0;
         o_fault <= 1'b0;
         alt_r <= 1'b0;
         oli_r <= 1'b0;
         o_analog_pct <= 7'h00;
         o_start_req <= 1'b0;
      end else begin
         // RQ2: sampled once after release
         if (!proto_done_r) begin
            o_modbus_sel <= i_port_protocol_switch;
            proto_done_r <= 1'b1;
         end
         // RQ3: node address and range check
         o_node_addr <= i_addr_switch;
         o_addr_valid <= i_addr_switch >= `SCIL_ADDR_MIN &&
                         i_addr_switch <= `SCIL_ADDR_MAX;
         o_analog_pct <= pct_nxt;
         // RQ24: one-cycle start request
         o_start_req <= st_r == SCIL_ST_IDLE && st_nxt == SCIL_ST_DELAY;
         // RQ16: set wins; reset only with no cause left
         if (trip || i_fault_cond) o_fault <= 1'b1;
         else if (reset_p) o_fault <= 1'b0;
         // RQ13: profile taken at start request
         if (st_r == SCIL_ST_IDLE && (rchg_r == 16'h0001))
            alt_r <= 1'b1;
         else if (st_r == SCIL_ST_IDLE && cmd_rise)
            alt_r <= alternate_ramp_select_in;
         // RQ21: inhibit captured before start, dropped at bypass
         if (st_r == SCIL_ST_IDLE) oli_r <= oldis_in;
         else if (o_bypass_close) oli_r <= 1'b0;
      end
   end

   // RQ12: run during enabled delay warns
   wire dly_warn = (term_cmd || i_net_run) &&
                   (!pon_done || st_r == SCIL_ST_DELAY || !rchg_ok);
   // RQ14: jog follows ramp, never bypasses
   assign o_jog          = jog_ok && st_r == SCIL_ST_IDLE;
   assign o_ramp         = st_r == SCIL_ST_RAMP || o_jog;
   assign o_run          = st_r == SCIL_ST_RUN;
   // RQ7: permissive loss begins a normal stop
   assign o_stop         = was_run_r && st_r == SCIL_ST_IDLE && !trip;
   assign o_hard_stop    = trip;
   assign o_bypass_close = st_r == SCIL_ST_RUN;
   assign o_alt_profile  = alt_r;
   assign o_local        = local_in;
   assign o_warning      = xwarn_t || an_warn || dly_warn;
   assign o_alarm_no_trip = ant_on;
   assign o_ol_inhibit   = oli_r && st_r != SCIL_ST_IDLE;

   // RQ23: relay decode, even codes inverted
   function automatic logic relay(input scil_code_t c);
      logic s;
      unique case ((c + 4'h1) >> 1)
         4'h1:    s = i_status.fault;
         4'h2:    s = i_status.bypassed;
         4'h3:    s = i_status.energized;
         4'h4:    s = i_status.warning;
         4'h5:    s = i_status.custom;
         default: s = 1'b0;
      endcase
      return (c != 4'h0) && (s ^ !c[0]);
   endfunction
   assign o_relay = {relay(rl_fn_r[1]), relay(rl_fn_r[0])};
endmodule

/* File: hw/scil_map.svh */
`ifndef SCIL_MAP_SVH
`define SCIL_MAP_SVH
// input function codes
`define SCIL_FN_NONE      4'h0
`define SCIL_FN_RUN       4'h1
`define SCIL_FN_ALTERNATE_RAMP_SELECT     4'h2
`define SCIL_FN_JOG       4'h3
`define SCIL_FN_LOCAL     4'h4
`define SCIL_FN_RESET     4'h5
`define SCIL_FN_ESTOP     4'h6
`define SCIL_FN_ANT       4'h7
`define SCIL_FN_XTRIP     4'h8
`define SCIL_FN_XWARN     4'h9
`define SCIL_FN_OLDIS     4'hA
`define SCIL_FN_ANALOG    4'hB
`define SCIL_FN_MAX_T13   4'hA
`define SCIL_FN_MAX_T4    4'hB
// input selector defaults
`define SCIL_IN1_DEF      4'h1
`define SCIL_IN2_DEF      4'h3
`define SCIL_IN3_DEF      4'h4
`define SCIL_IN4_DEF      4'h5
// relay function codes
`define SCIL_RL_MAX       4'hA
`define SCIL_RL1_DEF      4'h2
`define SCIL_RL2_DEF      4'h1
// field bus address limits
`define SCIL_ADDR_MIN     6'h01
`define SCIL_ADDR_MAX     6'h3F
// analog scale
`define SCIL_PCT_FULL     7'h64
// threshold action codes
`define SCIL_TH_OFF       2'h0
`define SCIL_TH_TRIP      2'h1
`define SCIL_TH_WARN      2'h2
`endif

/* File: hw/scil_pkg.sv */
package scil_pkg;
   typedef logic [3:0] scil_code_t;
   typedef enum logic [1:0] {
      SCIL_ST_IDLE, SCIL_ST_DELAY, SCIL_ST_RAMP, SCIL_ST_RUN
   } scil_state_e;
   typedef struct packed {
      logic [15:0] power_on;
      logic [15:0] start;
      logic [15:0] run_change;
   } scil_delays_s;
   typedef struct packed {
      logic fault;
      logic bypassed;
      logic energized;
      logic warning;
      logic custom;
   } scil_status_s;
endpackage

/* File: tb/scil_properties.sv */
`timescale 1ns/100ps
module scil_checker (
   // clock and reset
   input wire logic                   I_SYS_CLK,
   input wire logic                   I_RST,
   // inputs seen
   input wire logic                   i_permissive,
   input wire scil_pkg::scil_delays_s i_delays,
   input wire logic                   i_fault_cond,
   // outputs seen
   input wire logic                   o_modbus_sel,
   input wire logic [5:0]             o_node_addr,
   input wire logic                   o_addr_valid,
   input wire logic                   o_start_req,
   input wire logic                   o_run,
   input wire logic                   o_bypass_close,
   input wire logic                   o_jog,
   input wire logic                   o_fault,
   input wire logic [6:0]             o_analog_pct
);
   import scil_pkg::*;
   logic [16:0] up_r;
   // saturates so a long run never wraps
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST)
         up_r <= '0;
      else if (!up_r[16])
         up_r <= up_r + 17'h0_0001;
   end
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (I_RST);
   AST_ADDR_VALID: // zero is invalid
      assert property (o_addr_valid == (o_node_addr != 6'h00))
      else $error("address valid flag wrong");
   AST_PROTO_HELD: // sampled once
      assert property (up_r > 17'h0_0004 |-> $stable(o_modbus_sel))
      else $error("protocol select moved");
   AST_START_PULSE: // one cycle only
      assert property (o_start_req |=> !o_start_req)
      else $error("start request longer than one cycle");
   AST_NEEDS_PERMIT: // no permissive
      assert property (!i_permissive [*6] |-> !o_start_req)
      else $error("start without permissive");
   AST_PWRON_WAIT: // power-on delay
      assert property (o_start_req |-> up_r > {1'b0, i_delays.power_on})
      else $error("start inside power-on delay");
   AST_JOG_NO_BYPASS: // no bypass
      assert property (o_jog |-> !o_bypass_close)
      else $error("bypass closed while jogging");
   AST_FAULT_HELD: // cause remains
      assert property (i_fault_cond [*3] ##0 o_fault |=> o_fault)
      else $error("fault cleared with cause present");
   AST_PCT_RANGE: // full scale
      assert property (o_analog_pct <= 7'h64)
      else $error("analog percent above full scale");
   COV_START: cover property (o_start_req);
   COV_RUN: cover property (o_run && o_bypass_close);
   COV_FAULT: cover property (o_fault);
   COV_JOG: cover property (o_jog);
endmodule
bind scil_top scil_checker scil_checker_inst (
   .I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .i_permissive(i_permissive),
   .i_delays(i_delays), .i_fault_cond(i_fault_cond),
   .o_modbus_sel(o_modbus_sel), .o_node_addr(o_node_addr),
   .o_addr_valid(o_addr_valid), .o_start_req(o_start_req),
   .o_run(o_run), .o_bypass_close(o_bypass_close), .o_jog(o_jog),
   .o_fault(o_fault), .o_analog_pct(o_analog_pct)
);

/* File: tb/scil_field.sv */
`timescale 1ns/100ps
module scil_field (
   // clock
   input  wire logic       i_clk,
   // wanted contact levels
   input  wire logic       i_slow,
   input  wire logic       i_perm,
   input  wire logic [3:0] i_term,
   // levels at the terminals
   output logic            o_perm,
   output logic [3:0]      o_term
);
   logic [4:0] d0_r, d1_r, d2_r;
   // slow path stands in for a controller scan delay
   always_ff @(posedge i_clk) begin
      d0_r <= {i_perm, i_term};
      d1_r <= d0_r;
      d2_r <= d1_r;
   end
   // permissive kept as a maintained level
   assign {o_perm, o_term} = i_slow ? d2_r : {i_perm, i_term};
endmodule

/* File: tb/scil_top_tb.sv */
`timescale 1ns/100ps
module scil_top_tb;
   import scil_pkg::*;
   logic         clk, rst, perm, sns, prt, cwr, r2e, ndr, rdn, fc, slw;
   logic [3:0]   term, fterm;
   logic         fperm, mb, av, sr, rmp, run, byp, inch_motion_input, flt, wrn, ant;
   logic         stp, hs, loc;
   logic [5:0]   adr, na;
   scil_code_t   f0, f1, f2, f3, r0, r1, pr;
   scil_delays_s dl;
   scil_status_s st;
   logic [6:0]   ah, al, pct;
   logic [1:0]   aha, ala, rly;
   logic [11:0]  an;
   int           n_tests, n_mismatch, w;
   logic [3:0]   codes [4] = '{4'h6, 4'h7, 4'h8, 4'h9};
   scil_field scil_field_inst (.i_clk(clk), .i_slow(slw), .i_perm(perm),
      .i_term(term), .o_perm(fperm), .o_term(fterm));
   scil_top scil_top_inst (.I_SYS_CLK(clk), .I_RST(rst),
      .i_permissive(fperm), .i_terminal(fterm), .i_sense_mode_switch(sns),
      .i_port_protocol_switch(prt), .i_addr_switch(adr), .i_in_fn_0(f0),
      .i_in_fn_1(f1), .i_in_fn_2(f2), .i_in_fn_3(f3), .i_relay_fn_0(r0),
      .i_relay_fn_1(r1), .i_cfg_wr(cwr), .i_delays(dl),
      .i_alternate_ramp_select_enable(r2e), .i_an_high(ah), .i_an_low(al),
      .i_an_high_act(aha), .i_an_low_act(ala), .i_analog(an),
      .i_net_run(ndr), .i_ramp_done(rdn), .i_fault_cond(fc), .i_status(st),
      .o_modbus_sel(mb), .o_node_addr(na), .o_addr_valid(av),
      .o_start_req(sr), .o_ramp(rmp), .o_run(run), .o_stop(stp),
      .o_hard_stop(hs), .o_bypass_close(byp), .o_alt_profile(), .o_jog(inch_motion_input),
      .o_local(loc), .o_fault(flt), .o_warning(wrn), .o_alarm_no_trip(ant),
      .o_ol_inhibit(), .o_analog_pct(pct), .o_relay(rly));
   // even code inverts the odd one below it
   function automatic logic rl_exp(input logic [3:0] c, scil_status_s s);
      logic [4:0] v;
      v = {s.custom, s.warning, s.energized, s.bypassed, s.fault};
      return (c == 4'h0) ? 1'b0 : v[(c - 4'h1) >> 1] ^ ~c[0];
   endfunction
   function automatic logic [6:0] pct_exp(input logic [11:0] a);
      return 7'((32'(a) * 100) >> 12);
   endfunction
   task automatic cy(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic ck(input logic [6:0] g, e, input string m);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %0h exp %0h", $time, m, g, e);
      end
   endtask
   task automatic cfg;
      @(posedge clk);
      cwr <= 1'b1;
      @(posedge clk);
      cwr <= 1'b0;
   endtask
   // a reset pulse on terminal four, then a look once it has settled
   task automatic clr;
      cy(1);
      term[3] <= 1'b1;
      cy(3);
      term[3] <= 1'b0;
      cy(5);
      @(negedge clk);
   endtask
   task automatic finish_test;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // whole run needs a few hundred cycles; far more means a hang
   initial begin
      cy(20000);
      n_mismatch++;
      finish_test;
   end
   initial begin
      void'($urandom(68091));
      {perm, sns, cwr, r2e, ndr, rdn, fc, slw, prt, rst} = 10'h003;
      {term, adr, an, aha, ala, st} = '0;
      {f0, f1, f2, f3, r0, r1} = {4'h1, 4'h3, 4'h4, 4'h5, 4'h2, 4'h1};
      dl = {16'h0028, 16'h000A, 16'h0005};
      {ah, al} = {7'h50, 7'h10};
      {n_tests, n_mismatch} = '0;
      cy(2);
      rst <= 1'b0;
      ah <= 7'($urandom_range(100));
      al <= 7'($urandom_range(100));
      cy(6);
      prt <= 1'b0;
      cy(4);
      @(negedge clk);
      ck(mb, 7'h1, "protocol");
      ck(rly, 7'h1, "relay default");
      cy(1);
      perm <= 1'b1;
      term <= 4'b0101;
      cy(6);
      @(negedge clk);
      ck(wrn, 7'h1, "early run warning");
      ck(loc, 7'h1, "local select");
      for (w = 0; sr !== 1'b1 && w < 100; w++) @(negedge clk);
      ck(sr, 7'h1, "start request");
      for (w = 0; rmp !== 1'b1 && w < 40; w++) @(negedge clk);
      ck(7'(w >= 8 && w <= 12), 7'h1, "start delay");
      cy(1);
      rdn <= 1'b1;
      cy(4);
      @(negedge clk);
      ck({run, byp}, 7'h3, "run and bypass");
      cy(1);
      {term, rdn} <= {4'b0100, 1'b0};
      cy(4);
      @(negedge clk);
      ck(run, 7'h0, "level run removed");
      cy(1);
      {sns, slw, term} <= {2'b11, 4'b0101};
      cy(3);
      term <= 4'b0100;
      for (w = 0; sr !== 1'b1 && w < 40; w++) @(negedge clk);
      ck(sr, 7'h1, "edge start");
      cy(15);
      @(negedge clk);
      ck(rmp, 7'h1, "edge run latched");
      cy(1);
      perm <= 1'b0;
      for (w = 0; stp !== 1'b1 && w < 12; w++) @(negedge clk);
      ck(stp, 7'h1, "stop begun");
      cy(2);
      @(negedge clk);
      ck(rmp, 7'h0, "permissive lost");
      cy(1);
      {perm, sns, slw, fc} <= 4'b1001;
      clr;
      ck(flt, 7'h1, "fault kept");
      cy(1);
      fc <= 1'b0;
      clr;
      ck(flt, 7'h0, "fault cleared");
      foreach (codes[i]) begin
         cy(1);
         term[1] <= 1'b1;
         cy(3);
         f1 <= codes[i];
         cfg;
         cy(4);
         term[1] <= 1'b0;
         cy(5);
         @(negedge clk);
         ck(flt, 7'(codes[i] inside {4'h6, 4'h8}), "trip");
         ck(hs, 7'(codes[i] inside {4'h6, 4'h8}), "hard stop");
         ck(ant, 7'(codes[i] == 4'h7), "alarm no trip");
         ck(wrn, 7'(codes[i] == 4'h9), "warning");
         cy(1);
         term[1] <= 1'b1;
         clr;
         ck(flt, 7'h0, "trip reset");
      end
      repeat (24) begin
         cy(1);
         r0 <= 4'($urandom_range(10));
         r1 <= 4'($urandom_range(10));
         st <= 5'($urandom);
         cfg;
         cy(2);
         @(negedge clk);
         ck(rly, {rl_exp(r1, st), rl_exp(r0, st)}, "relay");
      end
      pr = r0;
      cy(1);
      r0 <= 4'hB;
      cfg;
      cy(2);
      @(negedge clk);
      ck(rly[0], rl_exp(pr, st), "relay code refused");
      for (int i = 0; i < 8; i++) begin
         cy(1);
         adr <= (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($urandom);
         cy(4);
         @(negedge clk);
         ck({av, na}, {adr != 6'h00, adr}, "address");
      end
      cy(1);
      f3 <= 4'hB;
      cfg;
      for (int i = 0; i < 8; i++) begin
         cy(1);
         an <= (i == 0) ? 12'hFFF : 12'($urandom);
         cy(5);
         @(negedge clk);
         ck(pct, pct_exp(an), "analog");
      end
      finish_test;
   end
endmodule
